// ==== hw/osc_carrier_end.sv ====
// carrier end: avalon-mm slave that runs module bus cycles
`timescale 1ns/10ps
`include "osc_consts.svh"
module osc_carrier_end (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // module bus
  osc_mbus_if.carrier bus
);
  osc_pkg::osc_host_state_t state;
  wire [7:0] word = address[9:2];
  wire request = read || write;
  wire toModule = word <= `OSC_AV_MODULE_TOP;
  wire toIack = word == `OSC_AV_IACK;
  wire toStatus = word == `OSC_AV_STATUS;
  wire idle = state == osc_pkg::OSC_H_IDLE;
  wire startCycle = idle && request && (toModule || toIack);
  wire startLocal = idle && request && !(toModule || toIack);
  wire acked = state == osc_pkg::OSC_H_STROBE && !bus.dtackN;
  wire [31:0] localValue =
    toStatus ? {31'h00000000, !bus.irqN} : 32'h00000000;

  assign waitrequest = state != osc_pkg::OSC_H_DONE;

  // --------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= osc_pkg::OSC_H_IDLE;
    end else begin
      unique case (state)
        osc_pkg::OSC_H_IDLE: begin
          if (startCycle) begin
            state <= osc_pkg::OSC_H_STROBE;
          end else if (startLocal) begin
            state <= osc_pkg::OSC_H_DONE;
          end
        end
        osc_pkg::OSC_H_STROBE: begin
          if (acked) begin
            state <= osc_pkg::OSC_H_RELEASE;
          end
        end
        osc_pkg::OSC_H_RELEASE: begin
          if (bus.dtackN) begin
            state <= osc_pkg::OSC_H_DONE;
          end
        end
        osc_pkg::OSC_H_DONE: begin
          state <= osc_pkg::OSC_H_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // bus drive
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.csN <= 1'b1;
      bus.ds0N <= 1'b1;
      bus.ds1N <= 1'b1;
      bus.iackN <= 1'b1;
      bus.writeN <= 1'b1;
      bus.hostOeN <= 1'b1;
      bus.addrHi <= 7'h00;
      bus.hostData <= 16'h0000;
    end else if (startCycle) begin
      bus.csN <= !toModule;
      bus.iackN <= !toIack;
      bus.ds0N <= 1'b0;
      bus.ds1N <= !toModule;
      bus.writeN <= !(write && toModule);
      bus.hostOeN <= !(write && toModule);
      bus.addrHi <= word[6:0];
      bus.hostData <= writedata[15:0];
    end else if (acked) begin
      bus.csN <= 1'b1;
      bus.ds0N <= 1'b1;
      bus.ds1N <= 1'b1;
      bus.iackN <= 1'b1;
      bus.writeN <= 1'b1;
      bus.hostOeN <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (acked) begin
      readdata <= {16'h0000, bus.dataBus};
    end else if (startLocal) begin
      readdata <= localValue;
    end
  end
endmodule : osc_carrier_end

// ==== hw/osc_consts.svh ====
// constants for the oscillator module bus, registers and carrier map
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// --------------------------------------------------------------------
// module register byte offsets
// --------------------------------------------------------------------
`define OSC_OFS_STATUS 8'h00
`define OSC_OFS_SETUP 8'h02
`define OSC_OFS_SERIAL 8'h04
`define OSC_OFS_IDSTORE 8'hFE

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define OSC_BIT_SERVICE 2
`define OSC_BIT_LOCKED 1
`define OSC_BIT_STYLE 7
`define OSC_BIT_SRV_PEND 6
`define OSC_BIT_LOCK_PEND 5
`define OSC_BIT_SER_PEND 4
`define OSC_BIT_MASTER 3
`define OSC_BIT_SRV_EN 2
`define OSC_BIT_LOCK_EN 1
`define OSC_BIT_SER_EN 0
`define OSC_BIT_IDWRITE 15

// --------------------------------------------------------------------
// sizes and special values
// --------------------------------------------------------------------
`define OSC_FIFO_DEPTH 512
`define OSC_FIFO_AW 9
`define OSC_RX_EMPTY_BYTE 8'hFF
`define OSC_ID_WORDS 64
`define OSC_ID_PTRW 10
`define OSC_ID_SYNC 16'h5346
`define OSC_ID_VXI_SYNC 16'hACBA
`define OSC_ID_W_SYNC 0
`define OSC_ID_W_MODNUM 1
`define OSC_ID_W_REV 2
`define OSC_ID_W_VXI_SYNC 16
`define OSC_ID_W_MAKER 17
`define OSC_ID_W_DEVTYPE 18
`define OSC_BUS_IDLE 16'hFFFF

// --------------------------------------------------------------------
// carrier avalon word map
// --------------------------------------------------------------------
`define OSC_AV_MODULE_TOP 8'h7F
`define OSC_AV_IACK 8'h80
`define OSC_AV_STATUS 8'h81

`endif

// ==== hw/osc_ext_id_store.sv ====
// bit-serial identification store, 64 words of 16 bits
`timescale 1ns/10ps
`include "osc_consts.svh"
module osc_ext_id_store #(
  parameter logic [15:0] MODULE_NUMBER = 16'h0123, // arbitrary value
  parameter logic [15:0] REVISION = 16'h0002,      // arbitrary value
  parameter logic [15:0] MAKER_ID = 16'h0ABC,      // arbitrary value
  parameter logic [15:0] DEVICE_TYPE = 16'hF456    // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // access
  input wire logic writeEn,
  input wire logic readEn,
  input wire logic [15:0] wdata,
  output logic bitOut
);
  logic [15:0] words [`OSC_ID_WORDS];
  logic [`OSC_ID_PTRW-1:0] bitPtr;
  wire writeBit = writeEn && wdata[`OSC_BIT_IDWRITE];
  wire loadPtr = writeEn && !wdata[`OSC_BIT_IDWRITE];
  wire [5:0] wordSel = bitPtr[`OSC_ID_PTRW-1:4];
  wire [3:0] bitSel = bitPtr[3:0];

  // --------------------------------------------------------------------
  // one bit per access
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bitPtr <= '0;
    end else if (loadPtr) begin
      bitPtr <= wdata[`OSC_ID_PTRW-1:0];
    end else if (writeBit || readEn) begin
      bitPtr <= bitPtr + 1'b1;
    end
  end

  assign bitOut = words[wordSel][bitSel];

  genvar w;
  generate
    for (w = 0; w < `OSC_ID_WORDS; w++) begin : g_word
      localparam logic [15:0] INIT =
        (w == `OSC_ID_W_SYNC) ? `OSC_ID_SYNC :
        (w == `OSC_ID_W_MODNUM) ? MODULE_NUMBER :
        (w == `OSC_ID_W_REV) ? REVISION :
        (w == `OSC_ID_W_VXI_SYNC) ? `OSC_ID_VXI_SYNC :
        (w == `OSC_ID_W_MAKER) ? MAKER_ID :
        (w == `OSC_ID_W_DEVTYPE) ? DEVICE_TYPE : 16'h0000;
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          words[w] <= INIT;
        end else if (writeBit && wordSel == 6'(w)) begin
          words[w][bitSel] <= wdata[0];
        end
      end
    end
  endgenerate
endmodule : osc_ext_id_store

// ==== hw/osc_mbus_if.sv ====
// module bus between carrier and oscillator module
`timescale 1ns/10ps
`include "osc_consts.svh"
interface osc_mbus_if;
  logic csN;
  logic [6:0] addrHi;
  logic writeN;
  logic ds0N;
  logic ds1N;
  logic iackN;
  logic irqN;
  logic dtackN;
  logic [15:0] hostData;
  logic hostOeN;
  logic [15:0] devData;
  logic devOeN;
  wire [15:0] dataBus;

  // pulled-up data lines resolved from the two enables
  assign dataBus = !devOeN ? devData :
                   !hostOeN ? hostData : `OSC_BUS_IDLE;

  modport device (
    input csN, addrHi, writeN, ds0N, ds1N, iackN, dataBus,
    output irqN, dtackN, devData, devOeN
  );
  modport carrier (
    input irqN, dtackN, dataBus,
    output csN, addrHi, writeN, ds0N, ds1N, iackN, hostData, hostOeN
  );
endinterface : osc_mbus_if

// ==== hw/osc_module_end.sv ====
// oscillator module end: register bank, interrupts, serial port, id store
`timescale 1ns/10ps
`include "osc_consts.svh"
// Contract
// - 16-bit asynchronous module bus with interrupt
// - status bit 1 shows lock
// - status bit 2 shows service needed
// - software trusts service bit only when locked
// - setup bit 7 picks interrupt style
// - bit 6 service pending, write one clears
// - bit 5 lock pending, write one clears
// - service/lock pending on any change, if enabled
// - serial pending only on rising condition
// - bit 3 master enable, reset disabled
// - bits 2..0 source enables, reset disabled
// - style C acknowledge returns setup bits 7..0
// - style C acknowledge clears master enable
// - handler re-enables master in style C
// - serial write sends byte to oscillator
// - serial read pops one received byte
// - empty receive buffer reads 0xFF
// - id store at FE, one bit per access
// - id store holds 64 words
// - active-low lock output, active-high lock lamp
// - active-low service output
// - receive buffer holds 512 bytes
module osc_module_end (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // module bus
  osc_mbus_if.device bus,
  // oscillator status
  input wire logic lockedFlag,
  input wire logic serviceNeededFlag,
  // serial link to oscillator
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic rxReady,
  // front panel
  output logic lockOutN,
  output logic lockLamp,
  output logic serviceOutN
);
  // --------------------------------------------------------------------
  // bus access decode
  // --------------------------------------------------------------------
  logic served;
  logic servedIack;
  logic [15:0] dataOut;
  wire [7:0] byteAddr = {bus.addrHi, 1'b0};
  wire anyStrobe = !bus.ds0N || !bus.ds1N;
  wire take = !bus.csN && anyStrobe && !served;
  wire iackTake = !bus.iackN && !bus.ds0N && !served && bus.csN;
  wire rdTake = take && bus.writeN;
  wire wrTake = take && !bus.writeN;
  wire hitStatus = byteAddr == `OSC_OFS_STATUS;
  wire hitSetup = byteAddr == `OSC_OFS_SETUP;
  wire hitSerial = byteAddr == `OSC_OFS_SERIAL;
  wire hitIdStore = byteAddr == `OSC_OFS_IDSTORE;
  wire [15:0] wdata = bus.dataBus;
  wire setupWr = wrTake && hitSetup;
  wire released = bus.csN && bus.iackN;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      served <= 1'b0;
      servedIack <= 1'b0;
    end else if (take || iackTake) begin
      served <= 1'b1;
      servedIack <= iackTake;
    end else if (released) begin
      served <= 1'b0;
      servedIack <= 1'b0;
    end
  end

  assign bus.dtackN = !served;
  assign bus.devOeN = !(served && (bus.writeN || servedIack));
  assign bus.devData = dataOut;

  // --------------------------------------------------------------------
  // receive buffer
  // --------------------------------------------------------------------
  logic [7:0] fifoMem [`OSC_FIFO_DEPTH];
  logic [`OSC_FIFO_AW-1:0] wrPtr;
  logic [`OSC_FIFO_AW-1:0] rdPtr;
  logic [`OSC_FIFO_AW:0] fillCount;
  wire fifoEmpty = fillCount == '0;
  wire fifoFull = fillCount == (`OSC_FIFO_AW+1)'(`OSC_FIFO_DEPTH);
  wire push = rxValid && !fifoFull;
  wire pop = rdTake && hitSerial && !fifoEmpty;
  wire [7:0] rxHead = fifoMem[rdPtr];

  assign rxReady = !fifoFull;

  always_ff @(posedge mclk) begin
    if (push) begin
      fifoMem[wrPtr] <= rxByte;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fillCount <= '0;
    end else begin
      wrPtr <= wrPtr + (`OSC_FIFO_AW)'(push);
      rdPtr <= rdPtr + (`OSC_FIFO_AW)'(pop);
      fillCount <= fillCount + (`OSC_FIFO_AW+1)'(push)
                   - (`OSC_FIFO_AW+1)'(pop);
    end
  end

  // --------------------------------------------------------------------
  // transmit
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txByte <= 8'h00;
      txValid <= 1'b0;
    end else begin
      txValid <= wrTake && hitSerial;
      if (wrTake && hitSerial) begin
        txByte <= wdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // interrupt setup and pending flags
  // --------------------------------------------------------------------
  logic interruptStyleSelect;
  logic masterIrqEnable;
  logic serviceIrqEnable;
  logic lockIrqEnable;
  logic serialIrqEnable;
  logic serviceEventPending;
  logic lockEventPending;
  logic serialEventPending;
  logic lockedPrev;
  logic servicePrev;
  logic nonEmptyPrev;

  wire srvChange = serviceNeededFlag != servicePrev;
  wire lockChange = lockedFlag != lockedPrev;
  wire serialRise = !fifoEmpty && !nonEmptyPrev;
  wire clrSrv = setupWr && wdata[`OSC_BIT_SRV_PEND];
  wire clrLock = setupWr && wdata[`OSC_BIT_LOCK_PEND];
  wire clrSer = setupWr && wdata[`OSC_BIT_SER_PEND];
  wire srvSet = srvChange && serviceIrqEnable;
  wire lockSet = lockChange && lockIrqEnable;
  wire serSet = serialRise && serialIrqEnable;
  wire next_serviceEventPending = srvSet || (serviceEventPending && !clrSrv);
  wire next_lockEventPending = lockSet || (lockEventPending && !clrLock);
  wire next_serialEventPending = serSet || (serialEventPending && !clrSer);
  wire styleC = interruptStyleSelect;
  wire next_masterIrqEnable =
    setupWr ? wdata[`OSC_BIT_MASTER] :
    (iackTake && styleC) ? 1'b0 : masterIrqEnable;

  wire [15:0] setupWord = {8'h00, interruptStyleSelect,
    serviceEventPending, lockEventPending, serialEventPending,
    masterIrqEnable, serviceIrqEnable, lockIrqEnable, serialIrqEnable};
  wire [15:0] statusWord =
    (16'(serviceNeededFlag) << `OSC_BIT_SERVICE) |
    (16'(lockedFlag) << `OSC_BIT_LOCKED);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      interruptStyleSelect <= 1'b0;
      masterIrqEnable <= 1'b0;
      serviceIrqEnable <= 1'b0;
      lockIrqEnable <= 1'b0;
      serialIrqEnable <= 1'b0;
    end else begin
      masterIrqEnable <= next_masterIrqEnable;
      if (setupWr) begin
        interruptStyleSelect <= wdata[`OSC_BIT_STYLE];
        serviceIrqEnable <= wdata[`OSC_BIT_SRV_EN];
        lockIrqEnable <= wdata[`OSC_BIT_LOCK_EN];
        serialIrqEnable <= wdata[`OSC_BIT_SER_EN];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      serviceEventPending <= 1'b0;
      lockEventPending <= 1'b0;
      serialEventPending <= 1'b0;
      lockedPrev <= 1'b0;
      servicePrev <= 1'b0;
      nonEmptyPrev <= 1'b0;
    end else begin
      serviceEventPending <= next_serviceEventPending;
      lockEventPending <= next_lockEventPending;
      serialEventPending <= next_serialEventPending;
      lockedPrev <= lockedFlag;
      servicePrev <= serviceNeededFlag;
      nonEmptyPrev <= !fifoEmpty;
    end
  end

  wire anyEnabledPending = (serviceEventPending && serviceIrqEnable) ||
    (lockEventPending && lockIrqEnable) ||
    (serialEventPending && serialIrqEnable);
  assign bus.irqN = !(masterIrqEnable && anyEnabledPending);

  // --------------------------------------------------------------------
  // identification store
  // --------------------------------------------------------------------
  logic idBit;

  osc_ext_id_store extendedIdentificationStore (
    .mclk(mclk),
    .reset(reset),
    .writeEn(wrTake && hitIdStore),
    .readEn(rdTake && hitIdStore),
    .wdata(wdata),
    .bitOut(idBit)
  );

  // --------------------------------------------------------------------
  // read data and acknowledge vector
  // --------------------------------------------------------------------
  wire [15:0] serialWord =
    fifoEmpty ? {8'h00, `OSC_RX_EMPTY_BYTE} : {8'h00, rxHead};
  wire [15:0] readValue =
    hitStatus ? statusWord :
    hitSetup ? setupWord :
    hitSerial ? serialWord :
    hitIdStore ? {15'h0000, idBit} : 16'h0000;
  wire [15:0] vectorWord = {8'h00, setupWord[7:0]};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dataOut <= 16'h0000;
    end else if (iackTake) begin
      dataOut <= vectorWord;
    end else if (rdTake) begin
      dataOut <= readValue;
    end
  end

  // --------------------------------------------------------------------
  // front panel
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lockOutN <= 1'b1;
      lockLamp <= 1'b0;
      serviceOutN <= 1'b1;
    end else begin
      lockOutN <= !lockedFlag;
      lockLamp <= lockedFlag;
      serviceOutN <= !serviceNeededFlag;
    end
  end
endmodule : osc_module_end

// ==== hw/osc_pkg.sv ====
// types used by the oscillator carrier end
package osc_pkg;

  typedef enum logic [1:0] {
    OSC_H_IDLE = 2'h0,
    OSC_H_STROBE = 2'h1,
    OSC_H_RELEASE = 2'h2,
    OSC_H_DONE = 2'h3
  } osc_host_state_t;

endpackage : osc_pkg

// ==== testbench/osc_bus_checker.sv ====
// bus checks between carrier and module ends
`timescale 1ns/10ps
module osc_bus_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // module bus
  input wire logic csN,
  input wire logic [6:0] addrHi,
  input wire logic writeN,
  input wire logic ds0N,
  input wire logic ds1N,
  input wire logic iackN,
  input wire logic irqN,
  input wire logic dtackN,
  input wire logic hostOeN,
  input wire logic devOeN,
  input wire logic [15:0] dataBus
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ------
  // phases
  // ------
  sequence accessStart;
    $fell(ds1N) && !csN;
  endsequence
  sequence devRead(logic [6:0] a);
    !devOeN && !csN && writeN && addrHi == a;
  endsequence
  sequence ackServed;
    !iackN && !dtackN && !devOeN && dataBus[7];
  endsequence
  sequence setupWrite;
    !dtackN && !csN && !writeN && addrHi == 7'h01;
  endsequence

  a_dtack_answer: assert property (accessStart |=> !dtackN)
    else $error("no acknowledge after strobe");
  a_dtack_cause: assert property ($fell(dtackN) |-> !$past(ds0N))
    else $error("acknowledge without strobe");
  a_no_contention: assert property (!(!devOeN && !hostOeN))
    else $error("both ends drive data");
  a_dtack_release: assert property ($rose(ds0N) |-> ##[0:2] dtackN)
    else $error("acknowledge held after release");
  a_status_zeros: assert property (devRead(7'h00) |->
    dataBus[15:3] == 13'h0000 && !dataBus[0])
    else $error("status unused bits set");
  a_setup_upper: assert property (devRead(7'h01) |->
    dataBus[15:8] == 8'h00) else $error("setup upper byte set");
  a_serial_upper: assert property (devRead(7'h02) |->
    dataBus[15:8] == 8'h00) else $error("serial upper byte set");
  a_id_one_bit: assert property (devRead(7'h7F) |->
    dataBus[15:1] == 15'h0000) else $error("id read wider than one bit");
  a_style_c_ack: assert property (ackServed |-> ##[1:4] irqN)
    else $error("request stays after style C acknowledge");
  a_master_off: assert property (setupWrite and !dataBus[3] |-> irqN)
    else $error("request with master disabled");
endmodule : osc_bus_checker

// ==== testbench/tb_top.sv ====
// self-checking bench for the carrier and module ends
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic lockedFlag = 1'b0;
  logic serviceNeededFlag = 1'b0;
  logic [7:0] txByte;
  logic txValid;
  logic [7:0] rxByte = 8'h00;
  logic rxValid = 1'b0;
  logic rxReady;
  logic lockOutN;
  logic lockLamp;
  logic serviceOutN;
  logic [7:0] lastTx = 8'h00;
  logic [31:0] q;
  int txCount = 0;
  int errors = 0;
  int compares = 0;

  osc_mbus_if bus ();
  osc_carrier_end osc_carrier_end_i (.mclk(mclk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .bus(bus));
  osc_module_end osc_module_end_i (.mclk(mclk), .reset(reset), .bus(bus),
    .lockedFlag(lockedFlag), .serviceNeededFlag(serviceNeededFlag),
    .txByte(txByte), .txValid(txValid), .rxByte(rxByte),
    .rxValid(rxValid), .rxReady(rxReady), .lockOutN(lockOutN),
    .lockLamp(lockLamp), .serviceOutN(serviceOutN));
  osc_bus_checker osc_bus_checker_i (.mclk(mclk), .reset(reset),
    .csN(bus.csN), .addrHi(bus.addrHi), .writeN(bus.writeN),
    .ds0N(bus.ds0N), .ds1N(bus.ds1N), .iackN(bus.iackN),
    .irqN(bus.irqN), .dtackN(bus.dtackN), .hostOeN(bus.hostOeN),
    .devOeN(bus.devOeN), .dataBus(bus.dataBus));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (txValid) begin
      lastTx <= txByte;
      txCount <= txCount + 1;
    end
  end

  // -------
  // helpers
  // -------
  task automatic summarize;
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task automatic av(input logic wr, input logic [9:0] a,
                    input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
    if (i == 100) begin
      errors++;
      summarize();
    end
  endtask : av

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    av(1'b1, a, d);
  endtask : wr

  task automatic fill(input int n, output int got);
    int i;
    got = 0;
    rxByte <= 8'h00;
    rxValid <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      if (rxReady !== 1'b1) break;
      got++;
      rxByte <= 8'(got);
    end
    rxValid <= 1'b0;
    @(posedge mclk);
  endtask : fill

  task automatic idw(input logic [9:0] p, input logic [15:0] exp);
    int i;
    logic [15:0] w;
    wr(10'h1FC, {22'h0, p});
    for (i = 0; i < 16; i++) begin
      av(1'b0, 10'h1FC, 32'h0);
      w[i] = q[0];
    end
    chk({16'h0, w}, {16'h0, exp});
  endtask : idw

  // ---------
  // scenarios
  // ---------
  task automatic t_reset;
    rd(10'h004, 32'h0);
    chkb(lockOutN, 1'b1);
    chkb(serviceOutN, 1'b1);
    rd(10'h00C, 32'h0);
  endtask : t_reset

  task automatic t_status;
    int i;
    for (i = 0; i < 4; i++) begin
      lockedFlag <= i[0];
      serviceNeededFlag <= i[1];
      repeat (4) @(posedge mclk);
      rd(10'h000, {29'h0, i[1], i[0], 1'b0});
      chkb(lockOutN, !i[0]);
      chkb(lockLamp, i[0]);
      chkb(serviceOutN, !i[1]);
    end
    rd(10'h000, 32'h6);
    rd(10'h004, 32'h0);
  endtask : t_status

  task automatic t_events;
    wr(10'h004, 32'h06);
    lockedFlag <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(10'h004, 32'h26);
    wr(10'h004, 32'h26);
    rd(10'h004, 32'h06);
    serviceNeededFlag <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(10'h004, 32'h46);
    wr(10'h004, 32'h46);
    rd(10'h004, 32'h06);
    lockedFlag <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(10'h004, 32'h26);
  endtask : t_events

  task automatic t_irq;
    rd(10'h204, 32'h0);
    wr(10'h004, 32'h0A);
    rd(10'h204, 32'h1);
    rd(10'h200, 32'h2A);
    rd(10'h004, 32'h2A);
    wr(10'h004, 32'h8A);
    rd(10'h200, 32'hAA);
    rd(10'h004, 32'hA2);
    rd(10'h204, 32'h0);
    wr(10'h004, 32'h8A);
    rd(10'h204, 32'h1);
    wr(10'h004, 32'h88);
    rd(10'h204, 32'h0);
    wr(10'h004, 32'h20);
    rd(10'h004, 32'h0);
  endtask : t_irq

  task automatic t_tx;
    wr(10'h008, 32'hA5);
    chk({24'h0, lastTx}, 32'hA5);
    wr(10'h008, 32'h3C);
    chk({24'h0, lastTx}, 32'h3C);
    chk(txCount, 2);
  endtask : t_tx

  task automatic t_rx;
    int n;
    int i;
    rd(10'h008, 32'hFF);
    wr(10'h004, 32'h01);
    fill(2, n);
    rd(10'h004, 32'h11);
    wr(10'h004, 32'h11);
    rd(10'h004, 32'h01);
    rd(10'h008, 32'h00);
    rd(10'h008, 32'h01);
    rd(10'h008, 32'hFF);
    fill(600, n);
    chk(n, 512);
    rd(10'h004, 32'h11);
    for (i = 0; i < 512; i++) begin
      rd(10'h008, {24'h0, i[7:0]});
    end
    rd(10'h008, 32'hFF);
  endtask : t_rx

  task automatic t_id;
    idw(10'h000, 16'h5346);
    idw(10'h100, 16'hACBA);
    wr(10'h1FC, 32'h3F0);
    wr(10'h1FC, 32'h8001);
    idw(10'h3F0, 16'h0001);
  endtask : t_id

  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_status();
    t_events();
    t_irq();
    t_tx();
    t_rx();
    t_id();
    summarize();
  end
endmodule : tb_top
